// ===== rtl/pfv_pkg.sv
// Purpose: Constants for the phase, frequency and input voltage command bank.
// Assumes: Command words arrive already decoded from the serial bus as code plus data.
// Notes: Threshold and frequency words are linear words, 5-bit exponent and 11-bit mantissa.
//
// Overview of operation
// - Config write while running: refuse, busy fault
// - Bit 7 routes channel 1 to channel 0 feedback
// - Bits 6:5 select input current sense gain
// - Bit 4 set: hold clock pin low below thresholds
// - Bit 4 clear: low only at first power-up
// - Bits 2:0 select the two channel phase offsets
// - Frequency word chosen from fixed code list
// - Frequency write while running: refuse, busy fault
// - Frequency change while off flags loop unlock
// - Frequency and thresholds are two-byte linear words
// - Input above overvoltage limit raises fault
// - Undervoltage warning armed after start and enable
// - Armed undervoltage warning sets status bits, alert
// - Conversion starts when input reaches start threshold
// - Conversion stops when input falls to stop threshold
package pfv_pkg;

  // Command codes
  localparam logic [7:0] CMD_START_THR = 8'h35;
  localparam logic [7:0] CMD_STOP_THR = 8'h36;
  localparam logic [7:0] CMD_OV_FAULT = 8'h55;
  localparam logic [7:0] CMD_UV_WARN = 8'h58;
  localparam logic [7:0] CMD_FILTER_RES = 8'hf7;
  localparam logic [7:0] CMD_PHASE_CFG = 8'hf5;
  localparam logic [7:0] CMD_FREQ_SEL = 8'h33;

  // Stored defaults
  localparam logic [15:0] RST_START_THR = 16'hcb40;
  localparam logic [15:0] RST_STOP_THR = 16'hcb00;
  localparam logic [15:0] RST_OV_FAULT = 16'he300;
  localparam logic [15:0] RST_UV_WARN = 16'hcb26;
  localparam logic [15:0] RST_FILTER_RES = 16'h12ee;
  localparam logic [7:0] RST_PHASE_CFG = 8'h10;
  localparam logic [15:0] RST_FREQ_SEL = 16'hfabc;

  // Phase configuration fields
  localparam int CFG_FB_SHARE_BIT = 7;
  localparam int CFG_GAIN_HI = 6;
  localparam int CFG_GAIN_LO = 5;
  localparam int CFG_CLK_HOLD_BIT = 4;
  localparam int CFG_PHASE_HI = 2;
  localparam int CFG_PHASE_LO = 0;

  // Linear word layout
  localparam int LIN_EXP_HI = 15;
  localparam int LIN_EXP_LO = 11;
  localparam int LIN_MAN_HI = 10;
  localparam int LIN_MAN_LO = 0;
  localparam int LIN_FRAC_BITS = 16;

  // Loop relock window after a frequency change
  localparam int PLL_SETTLE_NS = 10000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int PLL_SETTLE_CYC = (PLL_SETTLE_NS / CLK_PERIOD_NS < 1) ? 1 :
                                  PLL_SETTLE_NS / CLK_PERIOD_NS;

  // Status word input summary bit and input status undervoltage warning and overvoltage fault bits
  localparam int STW_INPUT_BIT = 13;
  localparam int STI_UV_WARN_BIT = 5;
  localparam int STI_OV_FAULT_BIT = 7;

endpackage

// ===== rtl/pfv_config_top.sv
// Purpose: Command bank for channel phasing, switching frequency and input voltage supervision.
// Assumes: Serial bus front end decodes each command into code, data and one-cycle strobes.
// Notes: Measured input arrives as a linear word from the converter, same clock domain.
module pfv_config_top #(
  parameter int SETTLE_CYC = pfv_pkg::PLL_SETTLE_CYC
) (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RST,
  // Decoded command port
  input wire logic [7:0] CMD_CODE,
  input wire logic CMD_WR,
  input wire logic CMD_RD,
  input wire logic [15:0] CMD_WDATA,
  output logic [15:0] CMD_RDATA,
  output logic CMD_ACK,
  output logic CMD_NACK,
  // Channel enables: pins and commanded on
  input wire logic [1:0] RUN_PIN,
  input wire logic [1:0] CH_CMD_ON,
  // Measured input voltage
  input wire logic [15:0] VIN_ADC_WORD,
  input wire logic VIN_ADC_VALID,
  // Fault handling
  input wire logic CLEAR_FAULTS,
  input wire logic ALERT_MASK_UV,
  output logic BUSY_FAULT,
  output logic VIN_OV_FAULT,
  output logic VIN_UV_WARN,
  output logic [15:0] STATUS_WORD,
  output logic [7:0] STATUS_INPUT,
  output logic ALERT_N_O,
  output logic ALERT_N_OE,
  // Shared clock pin, open drain
  input wire logic SHARE_CLK_I,
  output logic SHARE_CLK_O,
  output logic SHARE_CLK_OE,
  // Applied settings for the converter
  output logic CONV_ENABLE,
  output logic SHARED_FEEDBACK_SELECT,
  output logic [1:0] ISENSE_GAIN,
  output logic [2:0] PHASE_SEL,
  output logic [15:0] FREQ_CODE,
  output logic PLL_UNLOCK
);

  // Linear word to signed fixed point with 16 fraction bits
  function automatic logic signed [47:0] lin_value(input logic [15:0] w);
    logic signed [47:0] man;
    logic signed [5:0] sh;
    man = 48'(signed'(w[pfv_pkg::LIN_MAN_HI:pfv_pkg::LIN_MAN_LO]));
    sh = 6'(signed'(w[pfv_pkg::LIN_EXP_HI:pfv_pkg::LIN_EXP_LO])) + 6'sd16;
    lin_value = man <<< sh[4:0];
  endfunction

  function automatic logic freq_supported(input logic [15:0] w);
    unique case (w)
      16'h0000, 16'heb20, 16'hfbe8, 16'hf258, 16'hf2bc, 16'hf320, 16'hf384,
      16'hf3e8, 16'hfa58, 16'hfabc, 16'hfb52, 16'h023f, 16'h028a,
      16'h02ee: freq_supported = 1'b1;
      default: freq_supported = 1'b0;
    endcase
  endfunction

  // Run pins come from outside; two flops before use
  logic [1:0] run_meta_ff;
  logic [1:0] run_sync_ff;

  logic [15:0] start_thr_ff;
  logic [15:0] stop_thr_ff;
  logic [15:0] ov_lim_ff;
  logic [15:0] uv_lim_ff;
  logic [15:0] filt_res_ff;
  logic [7:0] cfg_ff;
  logic [15:0] freq_ff;
  logic [7:0] cfg_applied_ff;
  logic [15:0] freq_applied_ff;
  logic running_ff;
  logic vin_ok_ff;
  logic vin_seen_ff;
  logic uv_armed_ff;
  logic busy_ff;
  logic ov_ff;
  logic uv_ff;
  logic ack_ff;
  logic nack_ff;
  logic [15:0] rdata_ff;
  logic share_low_ff;
  logic alert_ff;
  logic in_sum_ff;
  logic pll_unlock_ff;
  logic [31:0] settle_cnt_ff;
  logic [31:0] nxt_settle_cnt;

  wire running = |(run_sync_ff & CH_CMD_ON);
  wire signed [47:0] vin_val = lin_value(VIN_ADC_WORD);
  wire above_start = VIN_ADC_VALID && (vin_val >= lin_value(start_thr_ff));
  wire below_stop = VIN_ADC_VALID && (vin_val <= lin_value(stop_thr_ff));
  wire over_ov = VIN_ADC_VALID && (vin_val > lin_value(ov_lim_ff));
  wire under_uv = VIN_ADC_VALID && (vin_val < lin_value(uv_lim_ff));

  // Command decode
  wire hit_start = CMD_CODE == pfv_pkg::CMD_START_THR;
  wire hit_stop = CMD_CODE == pfv_pkg::CMD_STOP_THR;
  wire hit_ov = CMD_CODE == pfv_pkg::CMD_OV_FAULT;
  wire hit_uv = CMD_CODE == pfv_pkg::CMD_UV_WARN;
  wire hit_filt = CMD_CODE == pfv_pkg::CMD_FILTER_RES;
  wire hit_cfg = CMD_CODE == pfv_pkg::CMD_PHASE_CFG;
  wire hit_freq = CMD_CODE == pfv_pkg::CMD_FREQ_SEL;
  wire hit_any = hit_start | hit_stop | hit_ov | hit_uv | hit_filt | hit_cfg | hit_freq;

  // Gated writes are refused while any channel runs
  wire cfg_busy = CMD_WR && hit_cfg && running;
  wire freq_busy = CMD_WR && hit_freq && running;
  // An unlisted frequency word is refused like an unknown command
  wire freq_bad = CMD_WR && hit_freq && !freq_supported(CMD_WDATA);
  wire wr_refuse = cfg_busy | freq_busy | freq_bad | (CMD_WR && !hit_any);
  wire wr_ok = CMD_WR && !wr_refuse;
  wire rd_ok = CMD_RD && hit_any;
  wire freq_changed = wr_ok && hit_freq && (CMD_WDATA != freq_ff);

  wire [15:0] rd_mux = hit_start ? start_thr_ff :
                       hit_stop ? stop_thr_ff :
                       hit_ov ? ov_lim_ff :
                       hit_uv ? uv_lim_ff :
                       hit_filt ? filt_res_ff :
                       hit_cfg ? {8'h00, cfg_ff} :
                       hit_freq ? freq_ff : 16'h0000;

  // Input qualification: start at or above one threshold, stop at the other
  wire nxt_vin_ok = above_start ? 1'b1 : below_stop ? 1'b0 : vin_ok_ff;
  wire nxt_vin_seen = vin_seen_ff | above_start;
  // Hold mode keeps the pin low whenever input is not qualified;
  // otherwise only before the input first qualifies.
  wire nxt_share_low = cfg_applied_ff[pfv_pkg::CFG_CLK_HOLD_BIT] ? !nxt_vin_ok :
                       !nxt_vin_seen;
  wire nxt_uv_armed = uv_armed_ff | (vin_seen_ff && running);

  // Sticky flags: set wins over clear
  wire nxt_busy = cfg_busy | freq_busy | (busy_ff & !CLEAR_FAULTS);
  wire nxt_ov = over_ov | (ov_ff & !CLEAR_FAULTS);
  wire nxt_uv = (uv_armed_ff && under_uv) | (uv_ff & !CLEAR_FAULTS);
  wire nxt_alert = nxt_ov | nxt_busy | (nxt_uv & !ALERT_MASK_UV);

  always_comb begin
    nxt_settle_cnt = settle_cnt_ff;
    if (freq_changed) begin
      nxt_settle_cnt = 32'(SETTLE_CYC);
    end else if (settle_cnt_ff != 32'h0000_0000) begin
      nxt_settle_cnt = settle_cnt_ff - 32'h0000_0001;
    end
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      run_meta_ff <= 2'h0;
      run_sync_ff <= 2'h0;
    end else begin
      run_meta_ff <= RUN_PIN;
      run_sync_ff <= run_meta_ff;
    end
  end

  // Stored command values
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      start_thr_ff <= pfv_pkg::RST_START_THR;
      stop_thr_ff <= pfv_pkg::RST_STOP_THR;
      ov_lim_ff <= pfv_pkg::RST_OV_FAULT;
      uv_lim_ff <= pfv_pkg::RST_UV_WARN;
      filt_res_ff <= pfv_pkg::RST_FILTER_RES;
      cfg_ff <= pfv_pkg::RST_PHASE_CFG;
      freq_ff <= pfv_pkg::RST_FREQ_SEL;
    end else if (wr_ok) begin
      if (hit_start) start_thr_ff <= CMD_WDATA;
      if (hit_stop) stop_thr_ff <= CMD_WDATA;
      if (hit_ov) ov_lim_ff <= CMD_WDATA;
      if (hit_uv) uv_lim_ff <= CMD_WDATA;
      if (hit_filt) filt_res_ff <= CMD_WDATA;
      if (hit_cfg) cfg_ff <= CMD_WDATA[7:0];
      if (hit_freq) freq_ff <= CMD_WDATA;
    end
  end

  // Settings reach the converter only at a rising enable, so a running
  // channel never sees its phase or frequency shift under it.
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      running_ff <= 1'b0;
      cfg_applied_ff <= pfv_pkg::RST_PHASE_CFG;
      freq_applied_ff <= pfv_pkg::RST_FREQ_SEL;
    end else begin
      running_ff <= running;
      if (running && !running_ff) begin
        cfg_applied_ff <= cfg_ff;
        freq_applied_ff <= freq_ff;
      end
    end
  end

  // Bus answers: one-cycle pulses, data held until the next read
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      ack_ff <= 1'b0;
      nack_ff <= 1'b0;
      rdata_ff <= 16'h0000;
    end else begin
      ack_ff <= wr_ok | rd_ok;
      nack_ff <= wr_refuse | (CMD_RD && !hit_any);
      if (rd_ok) rdata_ff <= rd_mux;
    end
  end

  // Input supervision and flags
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      vin_ok_ff <= 1'b0;
      vin_seen_ff <= 1'b0;
      uv_armed_ff <= 1'b0;
      share_low_ff <= 1'b1;
      busy_ff <= 1'b0;
      ov_ff <= 1'b0;
      uv_ff <= 1'b0;
      alert_ff <= 1'b0;
      in_sum_ff <= 1'b0;
      settle_cnt_ff <= 32'h0000_0000;
      pll_unlock_ff <= 1'b0;
    end else begin
      vin_ok_ff <= nxt_vin_ok;
      vin_seen_ff <= nxt_vin_seen;
      uv_armed_ff <= nxt_uv_armed;
      share_low_ff <= nxt_share_low;
      busy_ff <= nxt_busy;
      ov_ff <= nxt_ov;
      uv_ff <= nxt_uv;
      alert_ff <= nxt_alert;
      // Summary kept in its own flop so the status word leaves straight from a register
      in_sum_ff <= nxt_uv | nxt_ov;
      settle_cnt_ff <= nxt_settle_cnt;
      pll_unlock_ff <= nxt_settle_cnt != 32'h0000_0000;
    end
  end

  // Conversion follows the qualified input and the channel enables
  logic conv_ff;
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      conv_ff <= 1'b0;
    end else begin
      conv_ff <= nxt_vin_ok && running;
    end
  end

  assign CMD_RDATA = rdata_ff;
  assign CMD_ACK = ack_ff;
  assign CMD_NACK = nack_ff;
  assign BUSY_FAULT = busy_ff;
  assign VIN_OV_FAULT = ov_ff;
  assign VIN_UV_WARN = uv_ff;
  assign STATUS_WORD = {2'h0, in_sum_ff, 13'h0000};
  assign STATUS_INPUT = {ov_ff, 1'b0, uv_ff, 5'h00};
  assign ALERT_N_O = 1'b0;
  assign ALERT_N_OE = alert_ff;
  assign SHARE_CLK_O = 1'b0;
  assign SHARE_CLK_OE = share_low_ff;
  assign CONV_ENABLE = conv_ff;
  assign SHARED_FEEDBACK_SELECT = cfg_applied_ff[pfv_pkg::CFG_FB_SHARE_BIT];
  assign ISENSE_GAIN = cfg_applied_ff[pfv_pkg::CFG_GAIN_HI:pfv_pkg::CFG_GAIN_LO];
  assign PHASE_SEL = cfg_applied_ff[pfv_pkg::CFG_PHASE_HI:pfv_pkg::CFG_PHASE_LO];
  assign FREQ_CODE = freq_applied_ff;
  assign PLL_UNLOCK = pll_unlock_ff;

endmodule

// ===== test/pfv_config_checker.sv
// Purpose: Port-level checks for the phase, frequency and input command bank.
// Assumes: Alert mask stays low; running is rebuilt from levels held three samples.
// Notes: Settle count is handed on from the bank's parameter.
module pfv_config_checker #(
  parameter int SETTLE_CYC = 4
) (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RST,
  // Command port
  input wire logic [7:0] CMD_CODE,
  input wire logic CMD_WR,
  input wire logic CMD_RD,
  input wire logic CMD_ACK,
  input wire logic CMD_NACK,
  // Channel state
  input wire logic [1:0] RUN_PIN,
  input wire logic [1:0] CH_CMD_ON,
  // Flags and applied settings
  input wire logic BUSY_FAULT,
  input wire logic VIN_OV_FAULT,
  input wire logic VIN_UV_WARN,
  input wire logic [15:0] STATUS_WORD,
  input wire logic [7:0] STATUS_INPUT,
  input wire logic ALERT_N_OE,
  input wire logic CONV_ENABLE,
  input wire logic [2:0] PHASE_SEL,
  input wire logic [15:0] FREQ_CODE,
  input wire logic PLL_UNLOCK
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge MCLK);
  endclocking
  default disable iff (RST);
  int unlock_cnt_ff;
  logic conv_seen_ff;
  // Length of the current unlock run, and whether conversion was ever seen
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      unlock_cnt_ff <= 0;
      conv_seen_ff <= 1'b0;
    end else begin
      unlock_cnt_ff <= PLL_UNLOCK ? unlock_cnt_ff + 1 : 0;
      conv_seen_ff <= conv_seen_ff | CONV_ENABLE;
    end
  end
  AST_ANSWER: assert property (
    (CMD_WR || CMD_RD) |=> (CMD_ACK != CMD_NACK))
    else $error("strobe not answered by exactly one of ack, nack");
  AST_QUIET: assert property (
    !(CMD_WR || CMD_RD) |=> !(CMD_ACK || CMD_NACK))
    else $error("answer without a strobe");
  AST_BUSY: assert property (
    (|(RUN_PIN & CH_CMD_ON))[*3] ##0 (CMD_WR && CMD_CODE inside {8'hf5, 8'h33})
    |=> CMD_NACK ##1 BUSY_FAULT)
    else $error("write while running not refused with busy");
  AST_OV: assert property (
    VIN_OV_FAULT |-> ALERT_N_OE && STATUS_INPUT[7] && STATUS_WORD[13])
    else $error("overvoltage fault without status or alert");
  AST_UV: assert property (
    VIN_UV_WARN |-> ALERT_N_OE && STATUS_INPUT[5] && STATUS_WORD[13])
    else $error("undervoltage warning without status or alert");
  AST_UV_ARM: assert property (
    $rose(VIN_UV_WARN) |-> conv_seen_ff)
    else $error("undervoltage warning before arming");
  AST_CONV: assert property (
    CONV_ENABLE |-> |$past(CH_CMD_ON))
    else $error("conversion with no channel commanded on");
  AST_APPLY: assert property (
    ($changed(PHASE_SEL) || $changed(FREQ_CODE)) |-> |$past(CH_CMD_ON))
    else $error("applied setting changed outside enable");
  AST_PLL_LEN: assert property (
    $fell(PLL_UNLOCK) |-> unlock_cnt_ff == SETTLE_CYC)
    else $error("unlock window of wrong length");
endmodule

bind pfv_config_top pfv_config_checker #(.SETTLE_CYC(SETTLE_CYC)) u_chk (
  .MCLK(MCLK), .RST(RST), .CMD_CODE(CMD_CODE), .CMD_WR(CMD_WR), .CMD_RD(CMD_RD),
  .CMD_ACK(CMD_ACK), .CMD_NACK(CMD_NACK), .RUN_PIN(RUN_PIN), .CH_CMD_ON(CH_CMD_ON),
  .BUSY_FAULT(BUSY_FAULT), .VIN_OV_FAULT(VIN_OV_FAULT), .VIN_UV_WARN(VIN_UV_WARN),
  .STATUS_WORD(STATUS_WORD), .STATUS_INPUT(STATUS_INPUT), .ALERT_N_OE(ALERT_N_OE),
  .CONV_ENABLE(CONV_ENABLE), .PHASE_SEL(PHASE_SEL), .FREQ_CODE(FREQ_CODE),
  .PLL_UNLOCK(PLL_UNLOCK)
);

// ===== test/pfv_host_model.sv
// Purpose: Host stand-in issuing decoded command transfers to the bank.
// Assumes: Each strobe is answered by ack or nack a cycle after it is taken.
// Notes: Released code and data lines are inverted so stale values never pass.
module pfv_host_model (
  // Clock
  input wire logic mclk,
  // Command port
  output logic [7:0] cmd_code,
  output logic cmd_wr,
  output logic cmd_rd,
  output logic [15:0] cmd_wdata,
  input wire logic [15:0] cmd_rdata,
  input wire logic cmd_ack,
  input wire logic cmd_nack
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cmd_code = 8'h00;
    cmd_wr = 1'b0;
    cmd_rd = 1'b0;
    cmd_wdata = 16'h0000;
  end
  // Response 0 ack, 1 nack, 2 no answer within four edges
  task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] data,
                      output logic [1:0] resp, output logic [15:0] rdata);
    resp = 2'd2;
    rdata = 16'h0000;
    @(posedge mclk);
    cmd_code <= code;
    cmd_wdata <= data;
    cmd_wr <= wr;
    cmd_rd <= !wr;
    @(posedge mclk);
    cmd_wr <= 1'b0;
    cmd_rd <= 1'b0;
    cmd_code <= ~code;
    cmd_wdata <= ~data;
    for (int i = 0; i < 4 && resp == 2'd2; i++) begin
      @(posedge mclk);
      if (cmd_ack) resp = 2'd0;
      else if (cmd_nack) resp = 2'd1;
      rdata = cmd_rdata;
    end
  endtask
endmodule

// ===== test/tb_pwm_phase_freq_vin_config.sv
// Purpose: Self-checking bench for the phase, frequency and input command bank.
// Assumes: Host model makes every transfer; settle count shortened to four.
// Notes: Input words use exponent -7 near 6 V and -6 for the 13 V overvoltage case.
module tb_pwm_phase_freq_vin_config;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SETTLE = 4;
  typedef struct packed {logic [7:0] c; logic [15:0] rv; logic [15:0] nv;} pfv_row_t;
  pfv_row_t rows [7] = '{'{8'h35, 16'hcb40, 16'hcb50}, '{8'h36, 16'hcb00, 16'hcb10},
    '{8'h55, 16'he300, 16'hd300}, '{8'h58, 16'hcb26, 16'hcb30}, '{8'hf7, 16'h12ee, 16'h1000},
    '{8'hf5, 16'h0010, 16'h00d6}, '{8'h33, 16'hfabc, 16'hf258}};
  logic [15:0] freqs [15] = '{16'h0000, 16'heb20, 16'hfbe8, 16'hf258, 16'hf2bc, 16'hf320,
    16'hf384, 16'hf3e8, 16'hfa58, 16'hfabc, 16'hfb52, 16'hfbe8, 16'h023f, 16'h028a, 16'h02ee};
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] code;
  logic wr, rd, ack, nack, busy, ov, uv, clk_oe, conv, fb, unlock;
  logic [15:0] wdata, rdata, stw, freq, got;
  logic [7:0] sti;
  logic [1:0] gain, resp;
  logic [2:0] phase;
  logic [1:0] run_pin = 2'b00;
  logic [1:0] cmd_on = 2'b00;
  logic [15:0] vin = 16'h0000;
  logic vin_valid = 1'b0;
  logic clr = 1'b0;
  logic alert_oe;
  int error_cnt = 0;
  int compares = 0;
  always #5 mclk = ~mclk;
  pfv_config_top #(.SETTLE_CYC(SETTLE)) u_dut (.MCLK(mclk), .RST(rst), .CMD_CODE(code),
    .CMD_WR(wr), .CMD_RD(rd), .CMD_WDATA(wdata), .CMD_RDATA(rdata), .CMD_ACK(ack),
    .CMD_NACK(nack), .RUN_PIN(run_pin), .CH_CMD_ON(cmd_on), .VIN_ADC_WORD(vin),
    .VIN_ADC_VALID(vin_valid), .CLEAR_FAULTS(clr), .ALERT_MASK_UV(1'b0), .BUSY_FAULT(busy),
    .VIN_OV_FAULT(ov), .VIN_UV_WARN(uv), .STATUS_WORD(stw), .STATUS_INPUT(sti),
    .ALERT_N_O(), .ALERT_N_OE(alert_oe), .SHARE_CLK_I(!clk_oe), .SHARE_CLK_O(),
    .SHARE_CLK_OE(clk_oe), .CONV_ENABLE(conv), .SHARED_FEEDBACK_SELECT(fb),
    .ISENSE_GAIN(gain), .PHASE_SEL(phase), .FREQ_CODE(freq), .PLL_UNLOCK(unlock));
  pfv_host_model u_host (.mclk(mclk), .cmd_code(code), .cmd_wr(wr), .cmd_rd(rd),
    .cmd_wdata(wdata), .cmd_rdata(rdata), .cmd_ack(ack), .cmd_nack(nack));
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic acc(input logic w, input logic [7:0] c, input logic [15:0] d,
                     input logic [1:0] exp_resp);
    u_host.xfer(w, c, d, resp, got);
    if (resp == 2'd2) begin
      error_cnt++;
      $display("[FAIL] answer expected %h seen none", exp_resp);
      report_and_stop();
    end
    chk("response", 16'(exp_resp), 16'(resp));
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  initial begin
    cyc(20);
    rst <= 1'b0;
    cyc(1);
    chk("share hold", 16'h1, 16'(clk_oe));
    chk("freq", 16'hfabc, freq);
    foreach (rows[i]) begin
      acc(1'b0, rows[i].c, 16'h0000, 2'd0);
      chk("reset value", rows[i].rv, got);
      acc(1'b1, rows[i].c, rows[i].nv, 2'd0);
      acc(1'b0, rows[i].c, 16'h0000, 2'd0);
      chk("stored", rows[i].nv, got);
      cyc(SETTLE);
    end
    foreach (freqs[i]) begin
      acc(1'b1, 8'h33, freqs[i], 2'd0);
      chk("unlock", 16'h1, 16'(unlock));
      cyc(SETTLE + 2);
    end
    acc(1'b1, 8'h33, 16'h1234, 2'd1);
    acc(1'b0, 8'h20, 16'h0000, 2'd1);
    chk("busy", 16'h0, 16'(busy));
    chk("alert idle", 16'h0, 16'(alert_oe));
    vin_valid <= 1'b1;
    vin <= 16'hcb20;
    cyc(4);
    chk("uv early", 16'h0, 16'(uv));
    chk("share hold", 16'h1, 16'(clk_oe));
    vin <= 16'hcb80;
    cyc(4);
    chk("share free", 16'h0, 16'(clk_oe));
    chk("conv idle", 16'h0, 16'(conv));
    // Host keeps channels off for every accepted configuration write
    run_pin <= 2'b01;
    cmd_on <= 2'b01;
    cyc(6);
    chk("conv", 16'h1, 16'(conv));
    chk("feedback", 16'h1, 16'(fb));
    chk("gain", 16'h2, 16'(gain));
    chk("phase", 16'h6, 16'(phase));
    chk("freq", 16'h02ee, freq);
    acc(1'b1, 8'hf5, 16'h0010, 2'd1);
    chk("busy", 16'h1, 16'(busy));
    acc(1'b0, 8'hf5, 16'h0000, 2'd0);
    chk("cfg kept", 16'h00d6, got);
    acc(1'b1, 8'h33, 16'heb20, 2'd1);
    acc(1'b0, 8'h33, 16'h0000, 2'd0);
    chk("freq kept", 16'h02ee, got);
    vin <= 16'hcb20;
    cyc(4);
    chk("uv", 16'h1, 16'(uv));
    chk("status word", 16'h2000, stw);
    chk("alert", 16'h1, 16'(alert_oe));
    vin <= 16'hd340;
    cyc(4);
    chk("ov", 16'h1, 16'(ov));
    chk("status input", 16'h00a0, 16'(sti));
    vin <= 16'hcb00;
    cyc(4);
    chk("conv stop", 16'h0, 16'(conv));
    chk("share pull", 16'h1, 16'(clk_oe));
    run_pin <= 2'b00;
    cmd_on <= 2'b00;
    cyc(4);
    acc(1'b1, 8'hf5, 16'h0005, 2'd0);
    vin <= 16'hcb80;
    run_pin <= 2'b10;
    cmd_on <= 2'b10;
    cyc(6);
    chk("phase", 16'h5, 16'(phase));
    chk("gain", 16'h0, 16'(gain));
    chk("feedback", 16'h0, 16'(fb));
    vin <= 16'hcb00;
    cyc(4);
    chk("share free", 16'h0, 16'(clk_oe));
    // Clear while input still sits under the warning limit: the warning sets again
    clr <= 1'b1;
    cyc(1);
    clr <= 1'b0;
    cyc(2);
    chk("busy cleared", 16'h0, 16'(busy));
    chk("ov cleared", 16'h0, 16'(ov));
    chk("uv set wins", 16'h1, 16'(uv));
    report_and_stop();
  end
endmodule
